// File: hw/ett_timer.sv
// eight-bit timer core: counter, two compare channels, registers
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "ett_params.svh"
module ett_timer
  import ett_pkg::*;
#(
  parameter int ADDR_W = 3,
  parameter int PRESCALE_W = 10
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  input wire logic externalCountPin,
  input wire logic [2:0] vectorTaken,
  output logic [2:0] timerFlags,
  output logic chanAWaveOut,
  output logic chanAWaveEn,
  output logic chanBWaveOut,
  output logic chanBWaveEn
);

  // refuse address widths the register map cannot fit in
  if (ADDR_W < 3) begin : gAddrCheck
    $error("address too narrow for the register map");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] ctrlA_r, ctrlB_r, count_r, rdData_r;
  logic [2:0] flags_r;
  logic dirDown_r, blockMatch_r;
  logic [7:0] cmp_r [2];
  logic [7:0] cmpAct_r [2];
  logic [1:0] waveOut_r, waveEn_r;

  ett_wave_t waveMode;
  logic tick, isPwm, isFast, isPhase, waveHigh;
  logic [7:0] topVal;
  logic topEvt, ovfEvt, ctrlAWr, ctrlBWr, countWr, flagsWr;
  logic [1:0] matchEvt, forceEvt;
  logic [2:0] flagSet, flagClr;

  ett_tick_if tickIf ();

  ett_tick_gen #(
    .PRESCALE_W(PRESCALE_W)
  ) uTick (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .externalCountPin(externalCountPin),
    .tickIf(tickIf.gen)
  );

  assign tickIf.clkSel = ett_clksel_t'(ctrlB_r[`ETT_CLKSEL_POS +: 3]);
  assign tick = tickIf.tick;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  assign ctrlAWr = regWrStb && regAddr == ADDR_W'(`ETT_OFS_CTRL_A);
  assign ctrlBWr = regWrStb && regAddr == ADDR_W'(`ETT_OFS_CTRL_B);
  assign countWr = regWrStb && regAddr == ADDR_W'(`ETT_OFS_COUNT);
  assign flagsWr = regWrStb && regAddr == ADDR_W'(`ETT_OFS_FLAGS);

  assign waveHigh = ctrlB_r[`ETT_WAVE_HIGH_POS];
  assign waveMode = ett_wave_t'({waveHigh, ctrlA_r[`ETT_WAVE_LOW_POS +: 2]});
  assign isPwm = ctrlA_r[`ETT_WAVE_LOW_POS];
  assign isFast = isPwm && ctrlA_r[`ETT_WAVE_LOW_POS + 1];
  assign isPhase = isPwm && !ctrlA_r[`ETT_WAVE_LOW_POS + 1];

  always_comb begin
    unique case (waveMode)
      ETT_CLR_MATCH, ETT_PC_CMP, ETT_FAST_CMP: topVal = cmpAct_r[0];
      ETT_NORMAL, ETT_PC_FF, ETT_FAST_FF, ETT_RES4, ETT_RES6: topVal = `ETT_COUNT_MAX;
    endcase
  end

  assign topEvt = tick && count_r == topVal;

  always_comb begin
    unique case (waveMode)
      ETT_NORMAL, ETT_CLR_MATCH, ETT_FAST_FF: ovfEvt = tick && count_r == `ETT_COUNT_MAX;
      ETT_PC_FF, ETT_PC_CMP: ovfEvt = tick && dirDown_r && count_r == `ETT_COUNT_BOTTOM;
      ETT_FAST_CMP: ovfEvt = topEvt;
      ETT_RES4, ETT_RES6: ovfEvt = tick && count_r == `ETT_COUNT_MAX;
    endcase
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrlA_r <= `ETT_CTRL_RESET;
      ctrlB_r <= `ETT_CTRL_RESET;
    end else if (clkEn) begin
      if (ctrlAWr) begin
        ctrlA_r <= regWrData & `ETT_CTRL_A_MASK;
      end
      if (ctrlBWr) begin
        ctrlB_r <= regWrData & `ETT_CTRL_B_MASK;
      end
    end
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count_r <= `ETT_DATA_RESET;
      dirDown_r <= 1'b0;
    end else if (clkEn) begin
      if (!isPhase) begin
        dirDown_r <= 1'b0;
      end
      if (countWr) begin
        count_r <= regWrData;
      end else if (tick) begin
        if (isPhase) begin
          if (!dirDown_r) begin
            if (count_r == topVal) begin
              dirDown_r <= 1'b1;
              count_r <= count_r - 8'h01;
            end else begin
              count_r <= count_r + 8'h01;
            end
          end else if (count_r == `ETT_COUNT_BOTTOM) begin
            dirDown_r <= 1'b0;
            count_r <= count_r + 8'h01;
          end else begin
            count_r <= count_r - 8'h01;
          end
        end else if (isFast || waveMode == ETT_CLR_MATCH) begin
          count_r <= (count_r == topVal) ? `ETT_COUNT_BOTTOM : count_r + 8'h01;
        end else begin
          count_r <= count_r + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      blockMatch_r <= 1'b0;
    end else if (clkEn) begin
      if (countWr) begin
        blockMatch_r <= 1'b1;
      end else if (tick) begin
        blockMatch_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // compare channels
  // ----------------------------------------
  for (genvar ch = 0; ch < 2; ch++) begin : gChan
    localparam int ACT_POS = (ch == 0) ? `ETT_ACT_A_POS : `ETT_ACT_B_POS;
    localparam int FORCE_POS = (ch == 0) ? `ETT_FORCE_A_POS : `ETT_FORCE_B_POS;
    localparam logic [ADDR_W-1:0] CMP_OFS = (ch == 0) ?
      ADDR_W'(`ETT_OFS_CMP_A) : ADDR_W'(`ETT_OFS_CMP_B);
    logic [1:0] act;
    logic special, cmpWr, toggleOk;

    assign act = ctrlA_r[ACT_POS +: 2];
    assign cmpWr = regWrStb && regAddr == CMP_OFS;
    assign matchEvt[ch] = tick && !blockMatch_r && count_r == cmpAct_r[ch];
    assign forceEvt[ch] = ctrlBWr && regWrData[FORCE_POS] && !isPwm;
    assign special = act[1] && cmpAct_r[ch] == topVal;
    assign toggleOk = (ch == 0) && act == 2'b01 && waveHigh;

    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        cmp_r[ch] <= `ETT_DATA_RESET;
        cmpAct_r[ch] <= `ETT_DATA_RESET;
      end else if (clkEn) begin
        if (cmpWr) begin
          cmp_r[ch] <= regWrData;
        end
        if (!isPwm) begin
          cmpAct_r[ch] <= cmpWr ? regWrData : cmp_r[ch];
        end else if (topEvt) begin
          cmpAct_r[ch] <= cmp_r[ch];
        end
      end
    end

    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        waveOut_r[ch] <= 1'b0;
      end else if (clkEn) begin
        if (!isPwm) begin
          if (matchEvt[ch] || forceEvt[ch]) begin
            unique case (act)
              2'b00: waveOut_r[ch] <= waveOut_r[ch];
              2'b01: waveOut_r[ch] <= ~waveOut_r[ch];
              2'b10: waveOut_r[ch] <= 1'b0;
              2'b11: waveOut_r[ch] <= 1'b1;
            endcase
          end
        end else if (topEvt && act[1] && (isFast || special)) begin
          waveOut_r[ch] <= ~act[0];
        end else if (matchEvt[ch] && !special) begin
          if (act[1]) begin
            waveOut_r[ch] <= (isPhase && dirDown_r) ? ~act[0] : act[0];
          end else if (toggleOk) begin
            waveOut_r[ch] <= ~waveOut_r[ch];
          end
        end
      end
    end

    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        waveEn_r[ch] <= 1'b0;
      end else if (clkEn) begin
        waveEn_r[ch] <= act != 2'b00 && !(ch == 0 && isPwm && act == 2'b01 && !waveHigh);
      end
    end
  end

  assign chanAWaveOut = waveOut_r[0];
  assign chanBWaveOut = waveOut_r[1];
  assign chanAWaveEn = waveEn_r[0];
  assign chanBWaveEn = waveEn_r[1];

  // ----------------------------------------
  // flags
  // ----------------------------------------
  assign flagSet = {matchEvt[1], matchEvt[0], ovfEvt};
  assign flagClr = (flagsWr ? regWrData[2:0] : 3'h0) | vectorTaken;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flags_r <= 3'h0;
    end else if (clkEn) begin
      flags_r <= (flags_r & ~flagClr) | flagSet;
    end
  end

  assign timerFlags = flags_r;

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdData_r <= `ETT_DATA_RESET;
    end else if (clkEn) begin
      rdData_r <= 8'h00;
      if (regRdStb) begin
        unique case (regAddr)
          ADDR_W'(`ETT_OFS_CTRL_A): rdData_r <= ctrlA_r;
          ADDR_W'(`ETT_OFS_CTRL_B): rdData_r <= ctrlB_r;
          ADDR_W'(`ETT_OFS_COUNT): rdData_r <= count_r;
          ADDR_W'(`ETT_OFS_CMP_A): rdData_r <= cmp_r[0];
          ADDR_W'(`ETT_OFS_CMP_B): rdData_r <= cmp_r[1];
          ADDR_W'(`ETT_OFS_FLAGS): rdData_r <= {5'h00, flags_r};
          default: rdData_r <= 8'h00;
        endcase
      end
    end
  end

  assign regRdData = rdData_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_pin_enable_b: assert property (
    clkEn |=> chanBWaveEn == ($past(ctrlA_r[`ETT_ACT_B_POS +: 2]) != 2'b00))
    else $error("channel B pin enable does not follow action field");

  a_reserved_read: assert property (
    clkEn && regRdStb && regAddr == ADDR_W'(`ETT_OFS_CTRL_A) |=> regRdData[3:2] == 2'b00)
    else $error("reserved control A bits read nonzero");

  a_force_read_zero: assert property (
    clkEn && regRdStb && regAddr == ADDR_W'(`ETT_OFS_CTRL_B) |=> regRdData[7:4] == 4'h0)
    else $error("force or reserved bits read nonzero");

  a_nonpwm_clear_b: assert property (
    clkEn && !isPwm && ctrlA_r[`ETT_ACT_B_POS +: 2] == 2'b10 && matchEvt[1]
    |=> !chanBWaveOut)
    else $error("channel B not cleared on match");

  a_fast_top_set: assert property (
    clkEn && isFast && ctrlA_r[`ETT_ACT_B_POS +: 2] == 2'b10 && topEvt |=> chanBWaveOut)
    else $error("channel B not set at top in fast mode");

  a_phase_down_set: assert property (
    clkEn && isPhase && dirDown_r && ctrlA_r[`ETT_ACT_B_POS +: 2] == 2'b10
    && matchEvt[1] && !topEvt |=> chanBWaveOut)
    else $error("channel B not set on down-count match");

  a_force_no_clear: assert property (
    clkEn && waveMode == ETT_CLR_MATCH && forceEvt[0] && !tick && !countWr
    |=> count_r == $past(count_r) && flags_r[`ETT_FLAG_MATCH_A] == $past(flags_r[1]))
    else $error("forced compare touched counter or flag");

  a_pwm_force_idle: assert property (
    clkEn && isPwm && ctrlBWr && !tick
    |=> $stable(chanBWaveOut))
    else $error("force acted in a PWM mode");

  a_count_write: assert property (
    clkEn && countWr |=> count_r == $past(regWrData) && !matchEvt[0])
    else $error("counter write not taken or match not blocked");

  a_match_clear_wrap: assert property (
    clkEn && waveMode == ETT_CLR_MATCH && topEvt && !countWr |=> count_r == `ETT_COUNT_BOTTOM)
    else $error("clear-on-match mode did not wrap at compare A");

  a_ovf_normal: assert property (
    clkEn && waveMode == ETT_NORMAL && tick && count_r == `ETT_COUNT_MAX
    |=> flags_r[`ETT_FLAG_OVF])
    else $error("overflow flag not set at MAX");

  a_flag_clear: assert property (
    clkEn && flagsWr && regWrData[`ETT_FLAG_OVF] && !ovfEvt |=> !flags_r[`ETT_FLAG_OVF])
    else $error("overflow flag not cleared by one-write");

  c_fast_top: cover property (clkEn && isFast && topEvt);
  c_match_clear_wrap: cover property (clkEn && waveMode == ETT_CLR_MATCH && topEvt);
  c_phase_turn: cover property (clkEn && isPhase && topEvt ##[1:600] ovfEvt);
  c_force_a: cover property (clkEn && forceEvt[0]);

endmodule : ett_timer
`default_nettype wire

// File: hw/ett_params.svh
// constants for the eight-bit timer with two compare channels
`ifndef ETT_PARAMS_SVH
`define ETT_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ETT_OFS_CTRL_A 3'h0
`define ETT_OFS_CTRL_B 3'h1
`define ETT_OFS_COUNT 3'h2
`define ETT_OFS_CMP_A 3'h3
`define ETT_OFS_CMP_B 3'h4
`define ETT_OFS_FLAGS 3'h5

// ----------------------------------------
// field positions and masks
// ----------------------------------------
`define ETT_ACT_A_POS 6
`define ETT_ACT_B_POS 4
`define ETT_WAVE_LOW_POS 0
`define ETT_FORCE_A_POS 7
`define ETT_FORCE_B_POS 6
`define ETT_WAVE_HIGH_POS 3
`define ETT_CLKSEL_POS 0
`define ETT_CTRL_A_MASK 8'hf3
`define ETT_CTRL_B_MASK 8'h0f
`define ETT_FLAG_OVF 0
`define ETT_FLAG_MATCH_A 1
`define ETT_FLAG_MATCH_B 2

// ----------------------------------------
// reset values and counter limits
// ----------------------------------------
`define ETT_CTRL_RESET 8'h00
`define ETT_DATA_RESET 8'h00
`define ETT_COUNT_MAX 8'hff
`define ETT_COUNT_BOTTOM 8'h00

// ----------------------------------------
// prescaler divide ratios as tap widths
// ----------------------------------------
`define ETT_DIV8_BITS 3
`define ETT_DIV64_BITS 6
`define ETT_DIV256_BITS 8
`define ETT_DIV1024_BITS 10

`endif

// File: hw/ett_pkg.sv
// types shared by the timer modules
package ett_pkg;

  typedef enum logic [2:0] {
    ETT_NORMAL, ETT_PC_FF, ETT_CLR_MATCH, ETT_FAST_FF,
    ETT_RES4, ETT_PC_CMP, ETT_RES6, ETT_FAST_CMP
  } ett_wave_t;

  typedef enum logic [2:0] {
    ETT_CS_STOP, ETT_CS_DIV1, ETT_CS_DIV8, ETT_CS_DIV64,
    ETT_CS_DIV256, ETT_CS_DIV1024, ETT_CS_EXT_FALL, ETT_CS_EXT_RISE
  } ett_clksel_t;

endpackage : ett_pkg

// File: hw/ett_tick_if.sv
// clock-select request and timer tick between timer core and tick source
`timescale 1ns/10ps
`default_nettype none
interface ett_tick_if;
  import ett_pkg::*;
  ett_clksel_t clkSel;
  logic tick;
  modport gen (input clkSel, output tick);
  modport user (output clkSel, input tick);
endinterface : ett_tick_if
`default_nettype wire

// File: hw/ett_tick_gen.sv
// prescaler and external count pin edge detector producing the timer tick
`timescale 1ns/10ps
`default_nettype none
`include "ett_params.svh"
module ett_tick_gen
  import ett_pkg::*;
#(
  parameter int PRESCALE_W = 10
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic externalCountPin,
  ett_tick_if.gen tickIf
);

  if (PRESCALE_W < `ETT_DIV1024_BITS) begin : gWidthCheck
    $error("prescaler too narrow for the largest divide");
  end

  logic [PRESCALE_W-1:0] prescale_r;
  logic pinSync1_r, pinSync2_r, pinPrev_r, tick_r;
  logic pinRise, pinFall;

  // ----------------------------------------
  // free-running prescaler
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prescale_r <= '0;
    end else if (clkEn) begin
      prescale_r <= prescale_r + 1'b1;
    end
  end

  // ----------------------------------------
  // external pin synchroniser
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pinSync1_r <= 1'b0;
      pinSync2_r <= 1'b0;
      pinPrev_r <= 1'b0;
    end else if (clkEn) begin
      pinSync1_r <= externalCountPin;
      pinSync2_r <= pinSync1_r;
      pinPrev_r <= pinSync2_r;
    end
  end

  assign pinRise = pinSync2_r & ~pinPrev_r;
  assign pinFall = ~pinSync2_r & pinPrev_r;

  // ----------------------------------------
  // clock select
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tick_r <= 1'b0;
    end else if (clkEn) begin
      unique case (tickIf.clkSel)
        ETT_CS_STOP: tick_r <= 1'b0;
        ETT_CS_DIV1: tick_r <= 1'b1;
        ETT_CS_DIV8: tick_r <= &prescale_r[`ETT_DIV8_BITS-1:0];
        ETT_CS_DIV64: tick_r <= &prescale_r[`ETT_DIV64_BITS-1:0];
        ETT_CS_DIV256: tick_r <= &prescale_r[`ETT_DIV256_BITS-1:0];
        ETT_CS_DIV1024: tick_r <= &prescale_r[`ETT_DIV1024_BITS-1:0];
        ETT_CS_EXT_FALL: tick_r <= pinFall;
        ETT_CS_EXT_RISE: tick_r <= pinRise;
      endcase
    end
  end

  assign tickIf.tick = tick_r;

  a_ext_rise_tick: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && tickIf.clkSel == ETT_CS_EXT_RISE && pinRise |=> tickIf.tick)
    else $error("rising edge on count pin gave no tick");

  a_div8_spacing: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && tickIf.clkSel == ETT_CS_DIV8 && $past(tickIf.clkSel) == ETT_CS_DIV8
    && tickIf.tick |=> !tickIf.tick)
    else $error("divide by eight ticked twice in a row");

endmodule : ett_tick_gen
`default_nettype wire

// File: sim/eight_bit_timer_two_compare_tb.sv
// self-checking testbench for the eight-bit timer with two compare channels
`timescale 1ns/10ps
`default_nettype none
`include "ett_params.svh"
module eight_bit_timer_two_compare_tb;
  import ett_pkg::*;
  localparam logic [2:0] oCa = `ETT_OFS_CTRL_A;
  localparam logic [2:0] oCb = `ETT_OFS_CTRL_B;
  localparam logic [2:0] oCnt = `ETT_OFS_COUNT;
  localparam logic [2:0] oCmpA = `ETT_OFS_CMP_A;
  localparam logic [2:0] oCmpB = `ETT_OFS_CMP_B;
  localparam logic [2:0] oFlg = `ETT_OFS_FLAGS;
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic clkEn = 1'h1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrStb = 1'h0;
  logic regRdStb = 1'h0;
  logic [7:0] regRdData;
  logic externalCountPin = 1'h0;
  logic [2:0] vectorTaken = 3'h0;
  logic [2:0] timerFlags;
  logic chanAWaveOut, chanAWaveEn, chanBWaveOut, chanBWaveEn;
  int errors = 0;
  int nChecks = 0;
  logic [7:0] rv, d, o;
  int span [5] = '{20, 160, 1280, 5120, 20480};

  ett_timer #(.ADDR_W(3), .PRESCALE_W(10)) u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .externalCountPin(externalCountPin),
    .vectorTaken(vectorTaken), .timerFlags(timerFlags), .chanAWaveOut(chanAWaveOut),
    .chanAWaveEn(chanAWaveEn), .chanBWaveOut(chanBWaveOut), .chanBWaveEn(chanBWaveEn)
  );

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // bus tasks and comparisons
  // ----------------------------------------
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= v;
    regWrStb <= 1'h1;
    @(posedge ref_clk);
    regWrStb <= 1'h0;
  endtask : wr

  task rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regRdStb <= 1'h1;
    @(posedge ref_clk);
    regRdStb <= 1'h0;
    #1;
    v = regRdData;
  endtask : rd

  task settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : settle

  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    nChecks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task chk_near(input logic [7:0] got, input int exp, input int tol, input string what);
    nChecks++;
    if ($isunknown(got) || int'(got) < exp - tol || int'(got) > exp + tol) begin
      errors++;
      $display("ERROR t=%0t %s got %h near %0d", $time, what, got, exp);
    end
  endtask : chk_near

  // level expected on channel B away from the compare point
  function automatic logic pwm_exp(input logic [1:0] code, input logic [7:0] c,
                                   input logic [7:0] cb);
    return (c < cb) ^ code[0];
  endfunction : pwm_exp

  task run(input logic [7:0] b, input int n);
    wr(oCb, b);
    repeat (n) @(posedge ref_clk);
    wr(oCb, 8'h00);
    settle;
  endtask : run

  // compare value is loaded while in normal mode so it takes effect at once
  task pwm_scan(input logic [7:0] a, input logic [7:0] cb, input logic [1:0] code);
    logic [7:0] c;
    wr(oCa, 8'h00);
    wr(oCmpB, cb);
    wr(oCnt, 8'h00);
    wr(oCa, a | {2'h0, code, 4'h0});
    wr(oCb, 8'h01);
    repeat (600) @(posedge ref_clk);
    for (int k = 0; k < 12; k++) begin
      wr(oCb, 8'h00);
      settle;
      rd(oCnt, c);
      if (int'(c) > int'(cb) + 1 || int'(c) + 1 < int'(cb))
        chk({6'h0, chanBWaveEn, chanBWaveOut}, {7'h1, pwm_exp(code, c, cb)}, "pwm level");
      wr(oCb, 8'h01);
      repeat ($urandom_range(300, 5)) @(posedge ref_clk);
    end
    wr(oCb, 8'h00);
  endtask : pwm_scan

  task tally_and_finish;
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    // the sequence needs at most about 50000 cycles
    repeat (80000) @(posedge ref_clk);
    errors++;
    tally_and_finish;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rv = 8'($urandom(32'h43c3));
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'h0;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], rv);
      chk(rv, 8'h00, "reset or unmapped read");
    end
    wr(3'h7, 8'hff);
    rd(3'h7, rv);
    chk(rv, 8'h00, "unmapped write");
    // random writes keep force bits zero since PWM modes may be selected
    for (int i = 0; i < 16; i++) begin
      d = 8'($urandom());
      wr(oCa, d);
      rd(oCa, rv);
      chk(rv, d & 8'hf3, "control a");
      wr(oCb, d & 8'h38);
      rd(oCb, rv);
      chk(rv, d & 8'h08, "control b");
      wr(oCmpA, d);
      rd(oCmpA, rv);
      chk(rv, d, "compare a");
      wr(oCnt, ~d);
      rd(oCnt, rv);
      chk(rv, ~d, "counter");
    end
    wr(oCa, 8'h00);
    wr(oCb, 8'hc0);
    rd(oCb, rv);
    chk(rv, 8'h00, "force read");
    for (int s = 1; s < 6; s++) begin
      wr(oCnt, 8'h00);
      run(s[7:0], span[s-1]);
      rd(oCnt, rv);
      chk_near(rv, 20, 2, "prescaled count");
    end
    repeat (20) @(posedge ref_clk);
    rd(oCnt, o);
    chk(o, rv, "stopped count");
    // clock enable low freezes the tick stage, so only two ticks get through
    wr(oCnt, 8'h00);
    wr(oCb, 8'h01);
    clkEn <= 1'h0;
    repeat (50) @(posedge ref_clk);
    clkEn <= 1'h1;
    wr(oCb, 8'h00);
    settle;
    rd(oCnt, rv);
    chk(rv, 8'h02, "clock enable freeze");
    for (int e = 6; e < 8; e++) begin
      wr(oCnt, 8'h00);
      wr(oCb, e[7:0]);
      repeat (10) begin
        repeat (4) @(posedge ref_clk);
        externalCountPin <= 1'h1;
        repeat (4) @(posedge ref_clk);
        externalCountPin <= 1'h0;
      end
      repeat (8) @(posedge ref_clk);
      wr(oCb, 8'h00);
      settle;
      rd(oCnt, rv);
      chk(rv, 8'h0a, "external edges");
    end
    wr(oFlg, 8'h07);
    wr(oCnt, 8'hfc);
    run(8'h01, 8);
    chk({7'h0, timerFlags[0]}, 8'h01, "overflow at max");
    wr(oFlg, 8'h01);
    rd(oFlg, rv);
    chk(rv & 8'h01, 8'h00, "flag write clear");
    wr(oCnt, 8'hfc);
    run(8'h01, 8);
    @(posedge ref_clk);
    vectorTaken <= 3'h1;
    @(posedge ref_clk);
    vectorTaken <= 3'h0;
    settle;
    chk({7'h0, timerFlags[0]}, 8'h00, "vector clear");
    wr(oCmpB, 8'h05);
    wr(oCa, 8'h30);
    wr(oFlg, 8'h07);
    wr(oCb, 8'h40);
    settle;
    chk({6'h0, chanBWaveEn, chanBWaveOut}, 8'h03, "force set");
    chk({5'h0, timerFlags}, 8'h00, "force no flag");
    for (int c = 2; c >= 1; c--) begin
      wr(oCa, c[1:0] << 4);
      wr(oFlg, 8'h07);
      wr(oCnt, 8'h03);
      run(8'h01, 6);
      chk({7'h0, chanBWaveOut}, {7'h0, c[0]}, "match clear then toggle");
      chk({5'h0, timerFlags} & 8'h04, 8'h04, "match b flag");
    end
    wr(oCa, 8'h00);
    settle;
    chk({7'h0, chanBWaveEn}, 8'h00, "disconnected");
    wr(oCa, 8'h10);
    wr(oFlg, 8'h07);
    wr(oCnt, 8'h05);
    settle;
    o = {7'h0, chanBWaveOut};
    run(8'h01, 2);
    chk({7'h0, chanBWaveOut}, o, "match after counter write");
    chk({5'h0, timerFlags} & 8'h04, 8'h00, "no flag after counter write");
    wr(oCmpA, 8'h10);
    wr(oCnt, 8'h07);
    wr(oFlg, 8'h07);
    wr(oCa, 8'hc2);
    wr(oCb, 8'h80);
    settle;
    rd(oCnt, rv);
    chk(rv, 8'h07, "force keeps count");
    chk({6'h0, chanAWaveOut, timerFlags[1]}, 8'h02, "force a");
    run(8'h01, 40);
    rd(oCnt, rv);
    chk_near(rv, 8, 8, "clear on match top");
    chk({7'h0, timerFlags[1]}, 8'h01, "match a flag");
    pwm_scan(8'h03, 8'h40, 2'h2);
    pwm_scan(8'h03, 8'($urandom_range(8'hd0, 8'h20)), 2'h3);
    pwm_scan(8'h03, 8'hff, 2'h2);
    pwm_scan(8'h01, 8'h60, 2'h2);
    pwm_scan(8'h01, 8'($urandom_range(8'hd0, 8'h20)), 2'h3);
    wr(oCa, 8'h00);
    wr(oCmpA, 8'h30);
    wr(oFlg, 8'h07);
    wr(oCnt, 8'h00);
    wr(oCa, 8'h43);
    // run with the mode high bit set, then stop the clock but keep that bit so the pin stays owned
    wr(oCb, 8'h09);
    repeat (300) @(posedge ref_clk);
    wr(oCb, 8'h08);
    settle;
    chk({6'h0, chanAWaveEn, timerFlags[0]}, 8'h03, "toggle a and top overflow");
    rd(oCnt, rv);
    chk_near(rv, 24, 24, "compare a as top");
    wr(oCb, 8'h00);
    settle;
    chk({7'h0, chanAWaveEn}, 8'h00, "toggle a needs high bit");
    tally_and_finish;
  end
endmodule : eight_bit_timer_two_compare_tb
`default_nettype wire
